// File: dba_board.sv
// Board end: local bus arbiter, 256-word aperture FIFO and handshake
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Hold address/data enables low while DSP owns
// - Tie control tri-state input permanently low
// - DSP strobes each access, waits for ack
// - Board drives ack low when word done
// - All status high idle; any low requests
// - Lowest status low marks final burst word
// - Interrupt lines open-collector, driven by either side
// - Arbiter state, enables and ack change on rising local clock edge
// - DSP starts access: strobe low, status change
// - Grant only after PCI bridge cycle ends
// - Low ack means word taken next edge
// - FIFO full drops ack until drained
// - DSP holds last status until acked
// - Deadlock: PCI side first, then DSP back
// - DSP has priority; others after burst
// - Software may shorten bursts for PCI access
module dba_board
  import dba_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Local bus to DSP
  dba_if.board bus,
  // PCI bridge side
  input wire logic i_pci_busy,
  input wire logic i_pci_req,
  input wire logic i_pci_drain,
  output logic o_pci_grant,
  output logic o_pci_valid,
  output logic [DBA_DATA_W-1:0] o_pci_data,
  output logic [DBA_ADDR_W-1:0] o_pci_addr,
  output logic o_burst_done,
  // Host interrupts toward the DSP, DSP interrupts toward the host
  input wire logic [DBA_IRQ_W-1:0] i_host_irq,
  output logic [DBA_IRQ_W-1:0] o_dsp_irq
);
  dba_arb_state_t state_r;
  logic [1:0] div_r;
  logic local_bus_clk_r;
  logic lrise;
  logic strb_s1_r, strb_s2_r;
  logic [DBA_STAT_W-1:0] stat_s1_r, stat_s2_r;
  logic [DBA_DATA_W-1:0] data_s1_r, data_s2_r;
  logic [DBA_ADDR_W-1:0] addr_s1_r, addr_s2_r;
  logic [DBA_IRQ_W-1:0] irq_s1_r, irq_s2_r;
  logic pbusy_s1_r, pbusy_s2_r, preq_s1_r, preq_s2_r, pdrn_s1_r, pdrn_s2_r;
  logic ae_n_r, de_n_r, ack_n_r;
  logic [DBA_FIFO_CNT_W-1:0] fifo_cnt_r;
  logic [DBA_ADDR_W-1:0] addr_r;
  logic grant_r, burst_done_r;
  logic [DBA_IRQ_W-1:0] dsp_irq_r;
  logic [DBA_IRQ_W-1:0] host_s1_r, host_s2_r, brd_oe_b_r;
  logic dsp_req, last_word, fifo_full, take, buf_ready, buf_valid, pop;
  logic [DBA_DATA_W-1:0] buf_data;

  ////////////////////////////////////////////////////////////////////////////
  // Local bus clock divider; arbiter, enables and ack change on its rising edge, interrupt enables on every clock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= '0;
      local_bus_clk_r <= 1'b0;
    end else if (i_ce) begin
      div_r <= (div_r == DBA_LOCAL_BUS_CLK_DIV_MAX) ? 2'h0 : div_r + 2'h1;
      local_bus_clk_r <= (div_r < DBA_LOCAL_BUS_CLK_DIV_HALF);
    end
  end
  assign lrise = i_ce && (div_r == 2'h0);
  assign bus.local_bus_clk = local_bus_clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins and PCI side status
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strb_s1_r <= 1'b1;
      strb_s2_r <= 1'b1;
      stat_s1_r <= DBA_STAT_IDLE;
      stat_s2_r <= DBA_STAT_IDLE;
      data_s1_r <= '0;
      data_s2_r <= '0;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      irq_s1_r <= '1;
      irq_s2_r <= '1;
      pbusy_s1_r <= 1'b0;
      pbusy_s2_r <= 1'b0;
      preq_s1_r <= 1'b0;
      preq_s2_r <= 1'b0;
      pdrn_s1_r <= 1'b0;
      pdrn_s2_r <= 1'b0;
    end else if (i_ce) begin
      strb_s1_r <= bus.bus_strobe_n;
      strb_s2_r <= strb_s1_r;
      stat_s1_r <= bus.bus_status_lines;
      stat_s2_r <= stat_s1_r;
      data_s1_r <= bus.dsp_data_lines;
      data_s2_r <= data_s1_r;
      addr_s1_r <= bus.dsp_addr_lines;
      addr_s2_r <= addr_s1_r;
      irq_s1_r <= bus.shared_irq_lines;
      irq_s2_r <= irq_s1_r;
      pbusy_s1_r <= i_pci_busy;
      pbusy_s2_r <= pbusy_s1_r;
      preq_s1_r <= i_pci_req;
      preq_s2_r <= preq_s1_r;
      pdrn_s1_r <= i_pci_drain;
      pdrn_s2_r <= pdrn_s1_r;
    end
  end

  assign dsp_req = (stat_s2_r != DBA_STAT_IDLE) || !strb_s2_r;
  assign last_word = !stat_s2_r[DBA_STAT_LAST_BIT];
  assign fifo_full = (fifo_cnt_r == DBA_FIFO_CNT_W'(DBA_FIFO_DEPTH));
  // Word taken on the local edge where strobe and ack are both low
  assign take = lrise && (state_r == DBA_OWN) && !strb_s2_r && !ack_n_r;
  assign pop = buf_valid && !fifo_full;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= DBA_IDLE;
    end else if (lrise) begin
      case (state_r)
        DBA_IDLE: begin
          if (dsp_req) state_r <= DBA_WAIT_PCI;
        end
        DBA_WAIT_PCI: begin
          if (!pbusy_s2_r) state_r <= DBA_OWN;
        end
        DBA_OWN: begin
          if (take && last_word) state_r <= DBA_IDLE;
          else if (preq_s2_r && strb_s2_r) state_r <= DBA_YIELD;
        end
        DBA_YIELD: begin
          if (!preq_s2_r && !pbusy_s2_r) state_r <= DBA_OWN;
        end
        default: state_r <= DBA_IDLE;
      endcase
    end
  end

  // Enables and ack
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ae_n_r <= 1'b1;
      de_n_r <= 1'b1;
      ack_n_r <= 1'b1;
    end else if (lrise) begin
      ae_n_r <= !(state_r == DBA_OWN);
      de_n_r <= !(state_r == DBA_OWN);
      // Ack held off while FIFO or buffer cannot take a word
      // Enables must stand low a local period first, so the DSP lines carry the word when it is taken
      ack_n_r <= !((state_r == DBA_OWN) && !ae_n_r && !strb_s2_r && buf_ready && !fifo_full && !take);
    end
  end
  assign bus.addr_enable_n = ae_n_r;
  assign bus.data_enable_n = de_n_r;
  assign bus.ctrl_tristate_n = 1'b0;
  assign bus.xfer_ack_n = ack_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Aperture FIFO occupancy, drained by the PCI side
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fifo_cnt_r <= '0;
    end else if (i_ce) begin
      if (pop && !(pdrn_s2_r && fifo_cnt_r != '0)) fifo_cnt_r <= fifo_cnt_r + 1'b1;
      else if (!pop && pdrn_s2_r && fifo_cnt_r != '0) fifo_cnt_r <= fifo_cnt_r - 1'b1;
    end
  end

  dba_buf i_dba_buf (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_valid(take),
    .i_data(data_s2_r),
    .o_ready(buf_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(!fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // PCI side outputs and interrupts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pci_valid <= 1'b0;
      o_pci_data <= '0;
      addr_r <= '0;
      grant_r <= 1'b0;
      burst_done_r <= 1'b0;
      dsp_irq_r <= '0;
      host_s1_r <= '0;
      host_s2_r <= '0;
      brd_oe_b_r <= '1;
    end else if (i_ce) begin
      o_pci_valid <= pop;
      if (pop) o_pci_data <= buf_data;
      if (take) addr_r <= addr_s2_r;
      grant_r <= (state_r == DBA_IDLE) || (state_r == DBA_YIELD);
      burst_done_r <= take && last_word;
      dsp_irq_r <= ~irq_s2_r;
      host_s1_r <= i_host_irq;
      host_s2_r <= host_s1_r;
      brd_oe_b_r <= ~host_s2_r;
    end
  end
  assign o_pci_addr = addr_r;
  assign o_pci_grant = grant_r;
  assign o_burst_done = burst_done_r;
  assign o_dsp_irq = dsp_irq_r;
  assign bus.irq_brd_o = '0;
  assign bus.irq_brd_oe_b = brd_oe_b_r;
endmodule

// File: dba_pkg.sv
// Package: constants and types shared by the arbiter, the DSP end and the buffer
package dba_pkg;
  localparam int DBA_DATA_W = 32;
  localparam int DBA_ADDR_W = 31;
  localparam int DBA_STAT_W = 4;
  localparam int DBA_IRQ_W = 3;
  localparam int DBA_FIFO_DEPTH = 256;
  localparam int DBA_FIFO_CNT_W = 9;
  localparam int DBA_BUF_DEPTH = 2;
  localparam int DBA_BUF_IDX_W = 1;
  localparam int DBA_BUF_CNT_W = 2;
  localparam int DBA_STAT_LAST_BIT = 0;
  localparam logic [3:0] DBA_STAT_IDLE = 4'hf;
  localparam int DBA_CLK_PERIOD_NS = 10;
  localparam int DBA_LOCAL_BUS_CLK_PERIOD_NS = 30;
  localparam int DBA_LOCAL_BUS_CLK_DIV = DBA_LOCAL_BUS_CLK_PERIOD_NS / DBA_CLK_PERIOD_NS;
  localparam logic [1:0] DBA_LOCAL_BUS_CLK_DIV_MAX = 2'(DBA_LOCAL_BUS_CLK_DIV - 1);
  localparam logic [1:0] DBA_LOCAL_BUS_CLK_DIV_HALF = 2'(DBA_LOCAL_BUS_CLK_DIV / 2);
  typedef enum logic [1:0] {DBA_IDLE, DBA_WAIT_PCI, DBA_OWN, DBA_YIELD} dba_arb_state_t;
  typedef enum logic [1:0] {DBA_D_IDLE, DBA_D_BURST, DBA_D_LAST} dba_dsp_state_t;
endpackage

// File: dba_if.sv
// Interface: local bus wires between the DSP end and the board arbiter
`timescale 1ns/1ns
interface dba_if;
  import dba_pkg::*;
  logic local_bus_clk;
  logic addr_enable_n;
  logic data_enable_n;
  logic ctrl_tristate_n;
  logic bus_strobe_n;
  logic xfer_ack_n;
  logic [DBA_STAT_W-1:0] bus_status_lines;
  logic [DBA_ADDR_W-1:0] dsp_addr_lines;
  logic [DBA_DATA_W-1:0] dsp_data_lines;
  logic [DBA_IRQ_W-1:0] irq_dsp_o;
  logic [DBA_IRQ_W-1:0] irq_dsp_oe_b;
  logic [DBA_IRQ_W-1:0] irq_brd_o;
  logic [DBA_IRQ_W-1:0] irq_brd_oe_b;
  wire [DBA_IRQ_W-1:0] shared_irq_lines;
  // Open-collector wire: low if either party enables its pull-down
  assign shared_irq_lines = ~((~irq_dsp_oe_b & ~irq_dsp_o) | (~irq_brd_oe_b & ~irq_brd_o));
  modport board (
    output local_bus_clk, addr_enable_n, data_enable_n, ctrl_tristate_n, xfer_ack_n,
    input bus_strobe_n, bus_status_lines, dsp_addr_lines, dsp_data_lines, shared_irq_lines,
    output irq_brd_o, irq_brd_oe_b
  );
  modport dsp (
    input local_bus_clk, addr_enable_n, data_enable_n, ctrl_tristate_n, xfer_ack_n, shared_irq_lines,
    output bus_strobe_n, bus_status_lines, dsp_addr_lines, dsp_data_lines,
    output irq_dsp_o, irq_dsp_oe_b
  );
endinterface

// File: dba_buf.sv
// Two-entry valid/ready buffer in the data path
`timescale 1ns/1ns
module dba_buf
  import dba_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Fill side
  input wire logic i_valid,
  input wire logic [DBA_DATA_W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [DBA_DATA_W-1:0] o_data,
  input wire logic i_ready
);
  logic [DBA_DATA_W-1:0] mem_r [DBA_BUF_DEPTH];
  logic [DBA_BUF_IDX_W-1:0] wr_r;
  logic [DBA_BUF_IDX_W-1:0] rd_r;
  logic [DBA_BUF_CNT_W-1:0] cnt_r;
  logic push;
  logic pop;

  assign o_ready = (cnt_r != DBA_BUF_CNT_W'(DBA_BUF_DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data = mem_r[rd_r];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (i_ce) begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DBA_BUF_DEPTH; g++) begin : g_ent
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) mem_r[g] <= '0;
        else if (i_ce && push && wr_r == DBA_BUF_IDX_W'(g)) mem_r[g] <= i_data;
      end
    end
  endgenerate
endmodule

// File: dba_dsp.sv
// DSP end: synchronous burst master on the local bus
`timescale 1ns/1ns
module dba_dsp
  import dba_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Local bus to board
  dba_if.dsp bus,
  // User word stream
  input wire logic i_valid,
  input wire logic [DBA_DATA_W-1:0] i_data,
  input wire logic [DBA_ADDR_W-1:0] i_addr,
  input wire logic i_last,
  output logic o_ready,
  // Interrupts
  input wire logic [DBA_IRQ_W-1:0] i_irq_req,
  output logic [DBA_IRQ_W-1:0] o_irq_in
);
  dba_dsp_state_t state_r;
  logic local_bus_clk_s1_r, local_bus_clk_s2_r, local_bus_clk_d_r;
  logic ack_s1_r, ack_s2_r, ae_s1_r, ae_s2_r;
  logic [DBA_IRQ_W-1:0] irq_s1_r, irq_s2_r;
  logic strb_n_r, ready_r;
  logic [DBA_STAT_W-1:0] stat_r;
  logic [DBA_DATA_W-1:0] data_r;
  logic [DBA_ADDR_W-1:0] addr_r;
  logic [DBA_IRQ_W-1:0] irq_in_r;
  logic lrise, done;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      local_bus_clk_s1_r <= 1'b0;
      local_bus_clk_s2_r <= 1'b0;
      local_bus_clk_d_r <= 1'b0;
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      ae_s1_r <= 1'b1;
      ae_s2_r <= 1'b1;
      irq_s1_r <= '1;
      irq_s2_r <= '1;
    end else if (i_ce) begin
      local_bus_clk_s1_r <= bus.local_bus_clk;
      local_bus_clk_s2_r <= local_bus_clk_s1_r;
      local_bus_clk_d_r <= local_bus_clk_s2_r;
      ack_s1_r <= bus.xfer_ack_n;
      ack_s2_r <= ack_s1_r;
      ae_s1_r <= bus.addr_enable_n;
      ae_s2_r <= ae_s1_r;
      irq_s1_r <= bus.shared_irq_lines;
      irq_s2_r <= irq_s1_r;
    end
  end
  assign lrise = i_ce && local_bus_clk_s2_r && !local_bus_clk_d_r;
  assign done = lrise && !strb_n_r && !ack_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= DBA_D_IDLE;
      strb_n_r <= 1'b1;
      stat_r <= DBA_STAT_IDLE;
      data_r <= '0;
      addr_r <= '0;
      ready_r <= 1'b0;
    end else if (lrise) begin
      ready_r <= 1'b0;
      case (state_r)
        DBA_D_IDLE: begin
          if (i_valid) begin
            strb_n_r <= 1'b0;
            stat_r <= {3'h3, !i_last};
            data_r <= i_data;
            addr_r <= i_addr;
            ready_r <= 1'b1;
            state_r <= i_last ? DBA_D_LAST : DBA_D_BURST;
          end
        end
        DBA_D_BURST: begin
          if (done) begin
            if (i_valid) begin
              stat_r <= {3'h3, !i_last};
              data_r <= i_data;
              addr_r <= i_addr;
              ready_r <= 1'b1;
              if (i_last) state_r <= DBA_D_LAST;
            end else begin
              strb_n_r <= 1'b1;
            end
          end else if (strb_n_r && i_valid) begin
            strb_n_r <= 1'b0;
            stat_r <= {3'h3, !i_last};
            data_r <= i_data;
            addr_r <= i_addr;
            ready_r <= 1'b1;
            if (i_last) state_r <= DBA_D_LAST;
          end
        end
        DBA_D_LAST: begin
          // Last status stays low until the word is acknowledged
          if (done) begin
            strb_n_r <= 1'b1;
            stat_r <= DBA_STAT_IDLE;
            state_r <= DBA_D_IDLE;
          end
        end
        default: state_r <= DBA_D_IDLE;
      endcase
    end else if (i_ce) begin
      ready_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) irq_in_r <= '0;
    else if (i_ce) irq_in_r <= ~irq_s2_r;
  end

  assign o_ready = ready_r;
  assign o_irq_in = irq_in_r;
  assign bus.bus_strobe_n = strb_n_r;
  assign bus.bus_status_lines = stat_r;
  assign bus.dsp_data_lines = ae_s2_r ? '0 : data_r;
  assign bus.dsp_addr_lines = ae_s2_r ? '0 : addr_r;
  assign bus.irq_dsp_o = '0;
  assign bus.irq_dsp_oe_b = ~i_irq_req;
endmodule

// File: dba_monitor.sv
// Checker: handshake relations on the local bus between the two ends
`timescale 1ns/1ns
module dba_monitor
  import dba_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Local bus wires
  input wire logic local_bus_clk,
  input wire logic addr_enable_n,
  input wire logic data_enable_n,
  input wire logic ctrl_tristate_n,
  input wire logic bus_strobe_n,
  input wire logic xfer_ack_n,
  input wire logic [DBA_STAT_W-1:0] bus_status_lines
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [3:0] ack_age_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the acknowledge was last seen low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_age_r <= 4'hf;
    end else if (!xfer_ack_n) begin
      ack_age_r <= 4'h0;
    end else if (ack_age_r != 4'hf) begin
      ack_age_r <= ack_age_r + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_enables_pair;
    addr_enable_n == data_enable_n;
  endproperty
  a_enables_pair: assert property (p_enables_pair) else $error("enables differ");
  property p_tristate_low;
    !ctrl_tristate_n;
  endproperty
  a_tristate_low: assert property (p_tristate_low) else $error("control tristate not low");
  property p_ack_answers;
    $fell(xfer_ack_n) |-> !bus_strobe_n && !addr_enable_n;
  endproperty
  a_ack_answers: assert property (p_ack_answers) else $error("ack without owned strobe");
  property p_ack_width;
    $fell(xfer_ack_n) |-> !xfer_ack_n [*3] ##1 xfer_ack_n [*3];
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack not one local period");
  property p_grant_on_req;
    $fell(addr_enable_n) |-> bus_status_lines != DBA_STAT_IDLE;
  endproperty
  a_grant_on_req: assert property (p_grant_on_req) else $error("grant without request");
  property p_reset_idle;
    $rose(i_rst_b) |-> addr_enable_n && data_enable_n && xfer_ack_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
  property p_strobe_until_ack;
    $rose(bus_strobe_n) |-> ack_age_r < 4'h6;
  endproperty
  a_strobe_until_ack: assert property (p_strobe_until_ack) else $error("strobe dropped early");
  property p_local_bus_clk_period;
    $rose(local_bus_clk) |-> ##3 $rose(local_bus_clk);
  endproperty
  a_local_bus_clk_period: assert property (p_local_bus_clk_period) else $error("local clock period wrong");
  c_last: cover property ($fell(bus_status_lines[0]));
  c_ack: cover property ($fell(xfer_ack_n));
  c_release: cover property ($rose(addr_enable_n));
endmodule

// File: dsp_local_bus_burst_arbiter_bench.sv
// Testbench: DSP end and board end joined by the local bus interface
`timescale 1ns/1ns
module dsp_local_bus_burst_arbiter_bench;
  import dba_pkg::*;
  logic i_clk = 0;
  logic i_rst_b = 0;
  logic busy = 0, preq = 0, drain = 0, u_valid = 0, u_last = 0, u_ready, grant, pvalid, done;
  logic [31:0] u_data = 32'h0, pdata;
  logic [30:0] paddr;
  logic [2:0] host_irq = 3'h0, dsp_irq_req = 3'h0, brd_irq, dsp_irq;
  logic [31:0] cap[$];
  int error_cnt = 0, checks = 0, done_n = 0;
  dba_if bus_if();
  dba_board i_dba_board(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .bus(bus_if), .i_pci_busy(busy),
    .i_pci_req(preq), .i_pci_drain(drain), .o_pci_grant(grant), .o_pci_valid(pvalid), .o_pci_data(pdata),
    .o_pci_addr(paddr), .o_burst_done(done), .i_host_irq(host_irq), .o_dsp_irq(brd_irq));
  dba_dsp i_dba_dsp(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .bus(bus_if), .i_valid(u_valid),
    .i_data(u_data), .i_addr(u_data[30:0]), .i_last(u_last), .o_ready(u_ready), .i_irq_req(dsp_irq_req),
    .o_irq_in(dsp_irq));
  dba_monitor i_dba_monitor(.i_clk(i_clk), .i_rst_b(i_rst_b), .local_bus_clk(bus_if.local_bus_clk),
    .addr_enable_n(bus_if.addr_enable_n), .data_enable_n(bus_if.data_enable_n),
    .ctrl_tristate_n(bus_if.ctrl_tristate_n), .bus_strobe_n(bus_if.bus_strobe_n),
    .xfer_ack_n(bus_if.xfer_ack_n), .bus_status_lines(bus_if.bus_status_lines));
  always #5 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (pvalid === 1'b1) cap.push_back(pdata);
    if (done === 1'b1) done_n++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Present n words; valid stays up between words and drops after the last
  task automatic send(input int n, input logic [31:0] base);
    int t;
    for (int k = 0; k < n; k++) begin
      u_valid = 1'b1;
      u_data = base + 32'(k);
      u_last = (k == n - 1);
      t = 0;
      do begin
        @(negedge i_clk);
        t++;
      end while (u_ready !== 1'b1 && t < 20000);
      if (t >= 20000) begin
        error_cnt++;
        stop_test();
      end
    end
    u_valid = 1'b0;
    u_last = 1'b0;
  endtask
  task automatic pulse_drain(input int n);
    repeat (n) begin
      drain = 1'b1;
      @(negedge i_clk);
      drain = 1'b0;
      repeat (3) @(negedge i_clk);
    end
  endtask
  task automatic check_words(input int n, input logic [31:0] base);
    chk("word count", 32'(n), 32'(cap.size()));
    for (int k = 0; k < n && k < cap.size(); k++) chk("word", base + 32'(k), cap[k]);
    chk("last address", (base + 32'(n - 1)) & 32'h7fffffff, 32'(paddr));
    cap.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("enables", 32'h3, 32'({bus_if.addr_enable_n, bus_if.data_enable_n}));
    chk("ack", 32'h1, 32'(bus_if.xfer_ack_n));
    chk("status", 32'hf, 32'(bus_if.bus_status_lines));
    chk("tristate", 32'h0, 32'(bus_if.ctrl_tristate_n));
    $display("test reset done");
  endtask
  task automatic t_burst;
    busy = 1'b1;
    fork
      send(4, 32'ha5000000);
      begin
        repeat (40) @(negedge i_clk);
        chk("enables while bridge busy", 32'h1, 32'(bus_if.addr_enable_n));
        busy = 1'b0;
      end
    join
    repeat (30) @(negedge i_clk);
    check_words(4, 32'ha5000000);
    chk("burst end", 32'h1, 32'(done_n));
    chk("bus released", 32'h1, 32'(bus_if.addr_enable_n));
    preq = 1'b1;
    repeat (12) @(negedge i_clk);
    chk("host grant", 32'h1, 32'(grant));
    preq = 1'b0;
    pulse_drain(4);
    $display("test burst done");
  endtask
  task automatic t_full;
    int t;
    fork
      send(260, 32'h5a000000);
      begin
        t = 0;
        while (cap.size() < 256 && t < 20000) begin
          @(negedge i_clk);
          t++;
        end
        if (t >= 20000) begin
          error_cnt++;
          stop_test();
        end
        repeat (100) @(negedge i_clk);
        chk("held at full", 32'd256, 32'(cap.size()));
        chk("ack held off", 32'h1, 32'(bus_if.xfer_ack_n));
        pulse_drain(4);
      end
    join
    repeat (30) @(negedge i_clk);
    check_words(260, 32'h5a000000);
    pulse_drain(256);
    $display("test full done");
  endtask
  // One word, a gap with strobe high for a host deadlock, then the final word
  task automatic t_yield;
    int t;
    u_valid = 1'b1;
    u_data = 32'hc3000000;
    u_last = 1'b0;
    t = 0;
    do begin
      @(negedge i_clk);
      t++;
    end while (u_ready !== 1'b1 && t < 200);
    u_valid = 1'b0;
    if (t >= 200) begin
      error_cnt++;
      stop_test();
    end
    repeat (30) @(negedge i_clk);
    chk("grant while dsp owns", 32'h0, 32'(grant));
    chk("enables while dsp owns", 32'h0, 32'({bus_if.addr_enable_n, bus_if.data_enable_n}));
    preq = 1'b1;
    repeat (15) @(negedge i_clk);
    chk("enables in deadlock", 32'h1, 32'(bus_if.addr_enable_n));
    chk("host grant in deadlock", 32'h1, 32'(grant));
    preq = 1'b0;
    repeat (15) @(negedge i_clk);
    chk("enables given back", 32'h0, 32'(bus_if.addr_enable_n));
    send(1, 32'hc3000001);
    repeat (30) @(negedge i_clk);
    check_words(2, 32'hc3000000);
    chk("burst end", 32'h3, 32'(done_n));
    pulse_drain(2);
    $display("test yield done");
  endtask
  task automatic t_irq;
    dsp_irq_req = 3'h1;
    repeat (8) @(negedge i_clk);
    chk("host sees dsp irq", 32'h1, 32'(brd_irq));
    chk("shared line", 32'h6, 32'(bus_if.shared_irq_lines));
    dsp_irq_req = 3'h0;
    host_irq = 3'h4;
    repeat (8) @(negedge i_clk);
    chk("dsp sees host irq", 32'h4, 32'(dsp_irq));
    host_irq = 3'h0;
    $display("test irq done");
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    t_reset();
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    t_burst();
    t_full();
    t_yield();
    t_irq();
    stop_test();
  end
endmodule
